//--- logic/anp_next_page_mgr.v
// anp_next_page_mgr.v: next page exchange and management registers for auto-negotiation
// assumes: arbitration logic supplies received pages, base/next page completion and
//          page-taken pulses; management agent uses the register port below
//
// What this block and its management agent do
// R01: each next page toggle inverts previous toggle
// R02: first toggle is inverse of base D11
// R03: formatted flag one means message code page
// R04: never transmit a reserved message code
// R05: formatted flag zero means free code page
// R06: start exchange only if both advertise pages
// R07: continue until both last; else send null
// R08: free pages follow their message in order
// R09: send from transmit reg, store into receive reg
// R10: advertisement fields writable, reserved bits read-only
// R11: partner base register ignores management writes
// R12: partner base register mirrors received base page
// R13: completion sets status bit 1.5
// R14: management trusts partner base only after indication
// R15: expansion ignores writes, reserved bits zero
// R16: bit 6.2 reports next page support
// R17: new stored page sets page received
// R18: page received latches, cleared by reading
// R19: management reads received before writing transmit
// R20: transmit and receive next page registers exist
// R21: manual pause bits chosen for valid mode
// R22: management loads advertisement before negotiation
// R23: more pages zero on last page only
// R24: code field decoded by formatted flag
// R25: page loaded set by write, cleared by taking
// R26: reset returns all registers to defaults
`timescale 1ns/1ps
`include "anp_defs.vh"

module anp_next_page_mgr #(
   parameter NP_ABLE = 1
) (
   input wire i_clk,
   input wire i_rst,
   // management register port
   input wire [4:0] i_reg_addr,
   input wire i_reg_wr,
   input wire i_reg_rd,
   input wire [15:0] i_reg_wdata,
   output reg [15:0] o_reg_rdata,
   // arbitration side
   input wire i_an_restart,
   input wire i_an_complete,
   input wire i_rx_page_valid,
   input wire i_rx_is_base,
   input wire [15:0] i_rx_page,
   input wire i_base_done,
   input wire i_tx_page_taken,
   output reg [15:0] o_tx_config,
   output wire o_np_active,
   output wire o_np_done,
   output wire o_page_loaded,
   output wire o_an_complete,
   // decoded last received next page
   output reg o_rx_formatted,
   output reg [10:0] o_rx_msg_code,
   output reg [10:0] o_rx_free_code,
   output reg o_rx_comply
);

   // ****************************************
   // register port decode
   // ****************************************
   wire wr_advert;
   wire wr_np_tx;
   wire rd_expand;

   assign wr_advert = i_reg_wr && (i_reg_addr == `ANP_REG_ADVERT); // R10
   assign wr_np_tx = i_reg_wr && (i_reg_addr == `ANP_REG_NP_TX); // R09
   assign rd_expand = i_reg_rd && (i_reg_addr == `ANP_REG_EXPAND);

   // ****************************************
   // register storage
   // ****************************************
   wire [15:0] advert;
   wire [15:0] partner;
   wire [15:0] np_tx;
   wire [15:0] np_rx;
   wire rx_base_store;
   wire rx_next_store;

   assign rx_base_store = i_rx_page_valid && i_rx_is_base;
   assign rx_next_store = i_rx_page_valid && !i_rx_is_base;

   // reserved bits never take a written one
   anp_mgmt_reg #(
      .WMASK(`ANP_ADVERT_WMASK),
      .LMASK(`ANP_ALL_MASK),
      .RESET(`ANP_ADVERT_RST)
   ) u_advert (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_we(wr_advert), // R10
      .i_wdata(i_reg_wdata),
      .i_load(1'b0),
      .i_ldata(16'h0000),
      .o_q(advert)
   );

   // no write path at all, only the received base page
   anp_mgmt_reg #(
      .WMASK(`ANP_NONE_MASK),
      .LMASK(`ANP_PARTNER_MASK),
      .RESET(`ANP_PARTNER_RST)
   ) u_partner (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_we(1'b0), // R11
      .i_wdata(16'h0000),
      .i_load(rx_base_store), // R12
      .i_ldata(i_rx_page),
      .o_q(partner)
   );

   anp_mgmt_reg #(
      .WMASK(`ANP_ALL_MASK),
      .LMASK(`ANP_ALL_MASK),
      .RESET(`ANP_NP_TX_RST)
   ) u_np_tx (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_we(wr_np_tx), // R20
      .i_wdata(i_reg_wdata),
      .i_load(1'b0),
      .i_ldata(16'h0000),
      .o_q(np_tx)
   );

   // a later page overwrites; software is expected to read first
   anp_mgmt_reg #(
      .WMASK(`ANP_NONE_MASK),
      .LMASK(`ANP_ALL_MASK),
      .RESET(`ANP_NP_RX_RST)
   ) u_np_rx (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_we(1'b0), // R20
      .i_wdata(16'h0000),
      .i_load(rx_next_store), // R09
      .i_ldata(i_rx_page),
      .o_q(np_rx)
   );

   // ****************************************
   // status flags
   // ****************************************
   reg page_rx;
   reg an_done;
   reg loaded;
   reg [1:0] np_state;

   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         page_rx <= 1'b0; // R26
         an_done <= 1'b0;
         loaded <= 1'b0;
      end else begin
         // set beats the read clear in the same cycle
         if (i_rx_page_valid) begin
            page_rx <= 1'b1; // R17
         end else if (rd_expand) begin
            page_rx <= 1'b0; // R18
         end
         if (i_an_complete) begin
            an_done <= 1'b1; // R13
         end else if (i_an_restart) begin
            an_done <= 1'b0;
         end
         // a fresh write beats the taking of the older page
         if (wr_np_tx) begin
            loaded <= 1'b1; // R25
         end else if (i_tx_page_taken && np_state == `ANP_ST_NEXT) begin
            loaded <= 1'b0; // R25
         end else if (i_an_restart) begin
            loaded <= 1'b0;
         end
      end
   end

   assign o_page_loaded = loaded;
   assign o_an_complete = an_done;

   // ****************************************
   // outgoing page build
   // ****************************************
   reg [1:0] next_np_state;
   reg toggle;
   reg partner_last;
   reg [10:0] tx_code;
   reg [15:0] tx_page;
   reg [15:0] next_tx_config;
   wire code_reserved;
   wire both_np;

   // codes zero and above the defined range are reserved
   assign code_reserved = (np_tx[`ANP_CODE_MSB:0] == 11'h000) ||
      (np_tx[`ANP_CODE_MSB:0] > `ANP_MSG_MAX_DEF);
   assign both_np = advert[`ANP_BIT_MORE] && partner[`ANP_BIT_MORE]; // R06

   always @* begin
      tx_code = np_tx[`ANP_CODE_MSB:0];
      if (np_tx[`ANP_BIT_FMT] && code_reserved) begin
         tx_code = `ANP_NULL_CODE; // R04
      end
      if (loaded) begin
         // pages go out strictly in the order software loads them
         tx_page = {np_tx[15:12], toggle, tx_code}; // R08
      end else begin
         // nothing left: last page carrying the null message
         tx_page = {1'b0, 1'b0, 1'b1, 1'b0, toggle, `ANP_NULL_CODE}; // R07
      end
      // ack is owned by arbitration, sent here as zero
      tx_page[`ANP_BIT_ACK] = 1'b0;
   end

   always @* begin
      next_tx_config = o_tx_config;
      case (np_state)
         `ANP_ST_BASE: begin
            next_tx_config = advert;
         end
         `ANP_ST_NEXT: begin
            next_tx_config = tx_page; // R09
         end
         `ANP_ST_DONE: begin
            next_tx_config = o_tx_config;
         end
         default: begin
            next_tx_config = advert;
         end
      endcase
   end

   // ****************************************
   // exchange sequencing
   // ****************************************
   always @* begin
      next_np_state = np_state;
      case (np_state)
         `ANP_ST_BASE: begin
            if (i_base_done && both_np && NP_ABLE != 0) begin
               next_np_state = `ANP_ST_NEXT; // R06
            end
         end
         `ANP_ST_NEXT: begin
            // the pair just exchanged must be last on both ends
            if (i_tx_page_taken && !tx_page[`ANP_BIT_MORE] && partner_last) begin
               next_np_state = `ANP_ST_DONE; // R07 R23
            end
         end
         `ANP_ST_DONE: begin
            next_np_state = `ANP_ST_DONE;
         end
         default: begin
            next_np_state = `ANP_ST_BASE;
         end
      endcase
      if (i_an_restart) begin
         next_np_state = `ANP_ST_BASE;
      end
   end

   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         np_state <= `ANP_ST_BASE;
         toggle <= 1'b0;
         partner_last <= 1'b0;
         o_tx_config <= 16'h0000;
      end else begin
         np_state <= next_np_state;
         o_tx_config <= next_tx_config;
         if (np_state == `ANP_ST_BASE && i_base_done) begin
            toggle <= ~o_tx_config[`ANP_BIT_TOGGLE]; // R02
         end else if (np_state == `ANP_ST_NEXT && i_tx_page_taken) begin
            toggle <= ~toggle; // R01
         end
         if (i_an_restart || rx_base_store) begin
            partner_last <= 1'b0;
         end else if (rx_next_store) begin
            partner_last <= ~i_rx_page[`ANP_BIT_MORE];
         end
      end
   end

   assign o_np_active = (np_state == `ANP_ST_NEXT);
   assign o_np_done = (np_state == `ANP_ST_DONE);

   // ****************************************
   // received next page decode
   // ****************************************
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rx_formatted <= 1'b0;
         o_rx_msg_code <= 11'h000;
         o_rx_free_code <= 11'h000;
         o_rx_comply <= 1'b0;
      end else if (rx_next_store) begin
         o_rx_formatted <= i_rx_page[`ANP_BIT_FMT];
         o_rx_comply <= i_rx_page[`ANP_BIT_COMPLY];
         if (i_rx_page[`ANP_BIT_FMT]) begin
            o_rx_msg_code <= i_rx_page[`ANP_CODE_MSB:0]; // R03 R24
         end else begin
            // meaning set by the preceding message page
            o_rx_free_code <= i_rx_page[`ANP_CODE_MSB:0]; // R05 R24
         end
      end
   end

   // ****************************************
   // register read
   // ****************************************
   reg [15:0] next_rdata;

   always @* begin
      next_rdata = 16'h0000;
      case (i_reg_addr)
         `ANP_REG_STATUS: begin
            next_rdata[`ANP_BIT_AN_DONE] = an_done; // R13
         end
         `ANP_REG_ADVERT: begin
            next_rdata = advert;
         end
         `ANP_REG_PARTNER: begin
            next_rdata = partner;
         end
         `ANP_REG_EXPAND: begin
            // reserved bits stay zero
            next_rdata = `ANP_EXPAND_RST; // R15
            next_rdata[`ANP_BIT_NP_ABLE] = (NP_ABLE != 0); // R16
            next_rdata[`ANP_BIT_PAGE_RX] = page_rx; // R18
         end
         `ANP_REG_NP_TX: begin
            next_rdata = np_tx;
         end
         `ANP_REG_NP_RX: begin
            next_rdata = np_rx;
         end
         default: begin
            next_rdata = 16'h0000;
         end
      endcase
   end

   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_reg_rdata <= 16'h0000;
      end else if (i_reg_rd) begin
         o_reg_rdata <= next_rdata;
      end
   end

endmodule // anp_next_page_mgr

//--- logic/anp_defs.vh
// anp_defs.vh: register numbers, field positions, masks, reset values and codes
// assumes: included by every design file of the next page manager block
`ifndef ANP_DEFS_VH
`define ANP_DEFS_VH

// management register numbers (5-bit register address)
`define ANP_REG_STATUS 5'h01
`define ANP_REG_ADVERT 5'h04
`define ANP_REG_PARTNER 5'h05
`define ANP_REG_EXPAND 5'h06
`define ANP_REG_NP_TX 5'h07
`define ANP_REG_NP_RX 5'h08

// config word field positions
`define ANP_BIT_MORE 15
`define ANP_BIT_ACK 14
`define ANP_BIT_FMT 13
`define ANP_BIT_COMPLY 12
`define ANP_BIT_TOGGLE 11
`define ANP_CODE_MSB 10

// status and expansion bit positions
`define ANP_BIT_AN_DONE 5
`define ANP_BIT_NP_ABLE 2
`define ANP_BIT_PAGE_RX 1

// writable bits of the advertisement register: 15, 13:12, 8:7, 6, 5
`define ANP_ADVERT_WMASK 16'hB1E0
// defined bits of the mirrored partner base page: 15, 14, 13:12, 8:7, 6, 5
`define ANP_PARTNER_MASK 16'hF1E0
`define ANP_ALL_MASK 16'hFFFF
`define ANP_NONE_MASK 16'h0000

// reset values
`define ANP_ADVERT_RST 16'h0000
`define ANP_PARTNER_RST 16'h0000
`define ANP_NP_TX_RST 16'h0000
`define ANP_NP_RX_RST 16'h0000
`define ANP_EXPAND_RST 16'h0000

// message codes
`define ANP_NULL_CODE 11'h001
`define ANP_MSG_MAX_DEF 11'h00F

// next page exchange states
`define ANP_ST_BASE 2'h0
`define ANP_ST_NEXT 2'h1
`define ANP_ST_DONE 2'h2

`endif

//--- logic/anp_mgmt_reg.v
// anp_mgmt_reg.v: one 16-bit management register with write mask and hardware load
// assumes: one clock, asynchronous active-high reset, load and write never collide
//          on purpose; hardware load wins because it carries live link state
`timescale 1ns/1ps
`include "anp_defs.vh"

module anp_mgmt_reg #(
   parameter [15:0] WMASK = 16'hFFFF,
   parameter [15:0] LMASK = 16'hFFFF,
   parameter [15:0] RESET = 16'h0000
) (
   input wire i_clk,
   input wire i_rst,
   input wire i_we,
   input wire [15:0] i_wdata,
   input wire i_load,
   input wire [15:0] i_ldata,
   output reg [15:0] o_q
);

   reg [15:0] next_q;

   always @* begin
      next_q = o_q;
      if (i_load) begin
         next_q = i_ldata & LMASK;
      end else if (i_we) begin
         // read-only bits keep their stored value
         next_q = (o_q & ~WMASK) | (i_wdata & WMASK);
      end
   end

   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_q <= RESET;
      end else begin
         o_q <= next_q;
      end
   end

endmodule // anp_mgmt_reg

//--- sim/anp_chk.sv
// anp_chk.sv: port-level assertions for the next page manager
// assumes: bound to anp_next_page_mgr, one clock, async reset
`timescale 1ns/1ps
module anp_chk #(
   parameter NP_ABLE = 1
) (
   input wire i_clk,
   input wire i_rst,
   input wire [4:0] i_reg_addr,
   input wire i_reg_wr,
   input wire i_reg_rd,
   input wire [15:0] i_reg_wdata,
   input wire [15:0] o_reg_rdata,
   input wire i_an_complete,
   input wire i_rx_page_valid,
   input wire i_rx_is_base,
   input wire [15:0] i_rx_page,
   input wire i_base_done,
   input wire i_tx_page_taken,
   input wire [15:0] o_tx_config,
   input wire o_np_active,
   input wire o_page_loaded,
   input wire o_an_complete
);
   // ****
   // advertised more pages, both ends
   // ****
   reg adv_np;
   reg lp_np;
   wire rd6;
   wire vld;
   assign rd6 = i_reg_rd && i_reg_addr == 5'h06;
   assign vld = i_rx_page_valid;
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         adv_np <= 1'b0;
         lp_np <= 1'b0;
      end else begin
         if (i_reg_wr && i_reg_addr == 5'h04)
            adv_np <= i_reg_wdata[15];
         if (vld && i_rx_is_base)
            lp_np <= i_rx_page[15];
      end
   end
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);
   sequence s_enter;
      i_base_done ##1 o_np_active;
   endsequence
   sequence s_two_rd;
      (rd6 && !vld) ##1 !vld ##1 (rd6 && !vld);
   endsequence
   property p_exp_rd;
      rd6 |=> o_reg_rdata[15:3] == 13'h0000 && !o_reg_rdata[0] && o_reg_rdata[2] == (NP_ABLE != 0);
   endproperty
   a_exp_rd: assert property (p_exp_rd) else $error("expansion read wrong");
   property p_page_clr;
      s_two_rd |=> !o_reg_rdata[1];
   endproperty
   a_page_clr: assert property (p_page_clr) else $error("page received not cleared");
   property p_adv_rd;
      i_reg_rd && i_reg_addr == 5'h04 |=> (o_reg_rdata & 16'h4E1F) == 16'h0000;
   endproperty
   a_adv_rd: assert property (p_adv_rd) else $error("advert reserved bit set");
   property p_lp_rd;
      i_reg_rd && i_reg_addr == 5'h05 |=> (o_reg_rdata & 16'h0E1F) == 16'h0000;
   endproperty
   a_lp_rd: assert property (p_lp_rd) else $error("partner reserved bit set");
   property p_refuse;
      i_base_done && !o_np_active && !(adv_np && lp_np && NP_ABLE != 0) |=> !o_np_active;
   endproperty
   a_refuse: assert property (p_refuse) else $error("exchange began unadvertised");
   property p_toggle;
      i_tx_page_taken && o_np_active ##1 o_np_active |=> o_tx_config[11] != $past(o_tx_config[11], 2);
   endproperty
   a_toggle: assert property (p_toggle) else $error("toggle did not flip");
   property p_first;
      $rose(o_np_active) |=> o_tx_config[11] != $past(o_tx_config[11], 2);
   endproperty
   a_first: assert property (p_first) else $error("first toggle wrong");
   property p_null;
      s_enter ##0 !o_page_loaded |=> o_tx_config[15:12] == 4'h2 && o_tx_config[10:0] == 11'h001;
   endproperty
   a_null: assert property (p_null) else $error("null page not sent");
   property p_loaded;
      i_reg_wr && i_reg_addr == 5'h07 |=> o_page_loaded;
   endproperty
   a_loaded: assert property (p_loaded) else $error("page loaded not set");
   property p_done;
      i_an_complete |=> o_an_complete;
   endproperty
   a_done: assert property (p_done) else $error("complete not set");
endmodule // anp_chk
bind anp_next_page_mgr anp_chk #(.NP_ABLE(NP_ABLE)) i_anp_chk (.i_clk(i_clk), .i_rst(i_rst),
   .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
   .o_reg_rdata(o_reg_rdata), .i_an_complete(i_an_complete), .i_rx_page_valid(i_rx_page_valid),
   .i_rx_is_base(i_rx_is_base), .i_rx_page(i_rx_page), .i_base_done(i_base_done),
   .i_tx_page_taken(i_tx_page_taken), .o_tx_config(o_tx_config), .o_np_active(o_np_active),
   .o_page_loaded(o_page_loaded), .o_an_complete(o_an_complete));

//--- sim/anp_partner.sv
// anp_partner.sv: link partner arbitration model handing over pages
// assumes: bench calls its tasks; outputs move on the falling edge
`timescale 1ns/1ps
module anp_partner (
   input wire i_clk,
   output reg o_valid,
   output reg o_is_base,
   output reg [15:0] o_page,
   output reg o_base_done,
   output reg o_taken
);
   initial begin
      o_valid = 1'b0;
      o_is_base = 1'b0;
      o_page = 16'h0000;
      o_base_done = 1'b0;
      o_taken = 1'b0;
   end
   // page word released afterwards shows its inverse, never a stale copy
   task send(input b, input [15:0] p);
      begin
         @(negedge i_clk);
         o_valid = 1'b1;
         o_is_base = b;
         o_page = p;
         @(negedge i_clk);
         o_valid = 1'b0;
         o_page = ~p;
      end
   endtask
   task strobe(input b);
      begin
         @(negedge i_clk);
         o_base_done = b;
         o_taken = !b;
         @(negedge i_clk);
         o_base_done = 1'b0;
         o_taken = 1'b0;
      end
   endtask
endmodule // anp_partner

//--- sim/anp_next_page_mgr_tb.sv
// anp_next_page_mgr_tb.sv: self-checking bench with a register model
// assumes: design files under logic/, partner model and checker under sim/
`timescale 1ns/1ps
module anp_next_page_mgr_tb;
   reg i_clk;
   reg i_rst;
   reg [4:0] addr;
   reg mg_wr;
   reg mg_rd;
   reg [15:0] wd;
   reg rst_an;
   reg comp;
   wire [15:0] rdata;
   wire [15:0] txc;
   wire [15:0] page;
   wire valid, isb, bdone, taken, act, done, ld, anc, rfmt, rcom;
   wire [10:0] rmsg;
   wire [10:0] rfree;
   wire [15:0] rdata_n;
   wire act_n;
   integer error_cnt, num_checks, k;
   reg [15:0] m_adv, m_lp, m_np, m_tx;
   integer m_prx, m_comp;
   reg [31:0] lfsr;
   anp_partner i_anp_partner (.i_clk(i_clk), .o_valid(valid), .o_is_base(isb), .o_page(page),
      .o_base_done(bdone), .o_taken(taken));
   anp_next_page_mgr #(.NP_ABLE(1)) i_anp_next_page_mgr (.i_clk(i_clk), .i_rst(i_rst),
      .i_reg_addr(addr), .i_reg_wr(mg_wr), .i_reg_rd(mg_rd), .i_reg_wdata(wd), .o_reg_rdata(rdata),
      .i_an_restart(rst_an), .i_an_complete(comp), .i_rx_page_valid(valid), .i_rx_is_base(isb),
      .i_rx_page(page), .i_base_done(bdone), .i_tx_page_taken(taken), .o_tx_config(txc),
      .o_np_active(act), .o_np_done(done), .o_page_loaded(ld), .o_an_complete(anc),
      .o_rx_formatted(rfmt), .o_rx_msg_code(rmsg), .o_rx_free_code(rfree), .o_rx_comply(rcom));
   // same inputs, no next page support: able bit and refusal
   anp_next_page_mgr #(.NP_ABLE(0)) i_anp_next_page_mgr_nonp (.i_clk(i_clk), .i_rst(i_rst),
      .i_reg_addr(addr), .i_reg_wr(mg_wr), .i_reg_rd(mg_rd), .i_reg_wdata(wd), .o_reg_rdata(rdata_n),
      .i_an_restart(rst_an), .i_an_complete(comp), .i_rx_page_valid(valid), .i_rx_is_base(isb),
      .i_rx_page(page), .i_base_done(bdone), .i_tx_page_taken(taken), .o_tx_config(),
      .o_np_active(act_n), .o_np_done(), .o_page_loaded(), .o_an_complete(),
      .o_rx_formatted(), .o_rx_msg_code(), .o_rx_free_code(), .o_rx_comply());
   // ****
   // tasks
   // ****
   task close_out;
      begin
         $display("checks %0d errors %0d", num_checks, error_cnt);
         if (error_cnt == 0 && num_checks > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   task chk(input [15:0] got, input [15:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   function [15:0] mdl(input [4:0] a);
      case (a)
         5'h01: mdl = m_comp ? 16'h0020 : 16'h0000;
         5'h04: mdl = m_adv;
         5'h05: mdl = m_lp;
         5'h06: mdl = m_prx ? 16'h0006 : 16'h0004;
         5'h07: mdl = m_tx;
         5'h08: mdl = m_np;
         default: mdl = 16'h0000;
      endcase
   endfunction
   task rd(input [4:0] a);
      begin
         @(negedge i_clk);
         addr = a;
         mg_rd = 1'b1;
         @(negedge i_clk);
         mg_rd = 1'b0;
         chk(rdata, mdl(a));
         if (a == 5'h06)
            m_prx = 0;
      end
   endtask
   task wr(input [4:0] a, input [15:0] d);
      begin
         @(negedge i_clk);
         addr = a;
         wd = d;
         mg_wr = 1'b1;
         @(negedge i_clk);
         mg_wr = 1'b0;
         if (a == 5'h04)
            m_adv = d & 16'hB1E0;
         if (a == 5'h07)
            m_tx = d;
      end
   endtask
   task do_reset;
      begin
         i_rst = 1'b1;
         repeat (4) @(negedge i_clk);
         i_rst = 1'b0;
         {m_adv, m_lp, m_np, m_tx} = 64'h0000000000000000;
         m_prx = 0;
         m_comp = 0;
         for (k = 1; k < 9; k = k + 1)
            rd(k[4:0]);
         rd(5'h1F);
      end
   endtask
   // ****
   // clock, watchdog, sequence
   // ****
   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end
   initial begin
      #(2000 * 40);
      error_cnt = error_cnt + 1;
      close_out;
   end
   initial begin
      {addr, mg_wr, mg_rd, wd, rst_an, comp} = 25'h0000000;
      error_cnt = 0;
      num_checks = 0;
      lfsr = 32'h7F72;
      do_reset;
      for (k = 0; k < 4; k = k + 1) begin
         lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
         wr(5'h04, lfsr[15:0]);
         rd(5'h04);
      end
      wr(5'h05, 16'hFFFF);
      wr(5'h06, 16'hFFFF);
      rd(5'h05);
      rd(5'h06);
      chk(rdata_n, 16'h0000);
      $display("test registers done");
      i_anp_partner.send(1'b1, 16'hFFFF);
      m_lp = 16'hF1E0;
      m_prx = 1;
      rd(5'h06);
      rd(5'h06);
      rd(5'h05);
      i_anp_partner.send(1'b0, 16'hB005);
      m_np = 16'hB005;
      chk({15'h0000, rfmt}, 16'h0001);
      chk({5'h00, rmsg}, 16'h0005);
      chk({15'h0000, rcom}, 16'h0001);
      m_prx = 1;
      rd(5'h06);
      rd(5'h08);
      $display("test receive done");
      wr(5'h04, 16'h8020);
      i_anp_partner.strobe(1'b1);
      repeat (2) @(negedge i_clk);
      chk(txc, 16'h2801);
      chk({15'h0000, act_n}, 16'h0000);
      wr(5'h07, 16'hA002);
      @(negedge i_clk);
      chk(txc, 16'hA802);
      chk({15'h0000, ld}, 16'h0001);
      i_anp_partner.strobe(1'b0);
      repeat (2) @(negedge i_clk);
      chk(txc, 16'h2001);
      chk({15'h0000, ld}, 16'h0000);
      i_anp_partner.send(1'b0, 16'h0155);
      m_np = 16'h0155;
      m_prx = 1;
      chk({15'h0000, rfmt}, 16'h0000);
      chk({5'h00, rfree}, 16'h0155);
      // comply bit set so a substituted code differs from the idle null page
      wr(5'h07, 16'h37FF);
      @(negedge i_clk);
      chk(txc, 16'h3001);
      i_anp_partner.strobe(1'b0);
      repeat (2) @(negedge i_clk);
      chk({15'h0000, done}, 16'h0001);
      chk({15'h0000, act}, 16'h0000);
      $display("test exchange done");
      @(negedge i_clk);
      comp = 1'b1;
      @(negedge i_clk);
      comp = 1'b0;
      m_comp = 1;
      chk({15'h0000, anc}, 16'h0001);
      rd(5'h01);
      rst_an = 1'b1;
      @(negedge i_clk);
      rst_an = 1'b0;
      m_comp = 0;
      chk({15'h0000, anc}, 16'h0000);
      wr(5'h04, 16'h0020);
      i_anp_partner.strobe(1'b1);
      repeat (2) @(negedge i_clk);
      chk({15'h0000, act}, 16'h0000);
      rd(5'h01);
      $display("test refuse done");
      do_reset;
      $display("test reset done");
      close_out;
   end
endmodule // anp_next_page_mgr_tb
